/* File: ebp_pkg.sv */
// Purpose: Shared constants for the enhanced bridge PWM block
// Assumes: hclk is the oscillator clock; one instruction cycle is four hclk
// Notes: Offsets are byte addresses on the AHB-Lite register window
package ebp_pkg;

	// Register byte offsets
	localparam logic [7:0] ADDR_PERIOD_LIMIT = 8'h00;
	localparam logic [7:0] ADDR_PERIOD_TIMER = 8'h04;
	localparam logic [7:0] ADDR_DUTY_LOW = 8'h08;
	localparam logic [7:0] ADDR_DUTY_SHADOW = 8'h0c;
	localparam logic [7:0] ADDR_CONTROL = 8'h10;
	localparam logic [7:0] ADDR_TIMER_CTRL = 8'h14;
	localparam logic [7:0] ADDR_DELAY_CFG = 8'h18;
	localparam logic [7:0] ADDR_SHUTDOWN = 8'h1c;

	// Reset values
	localparam logic [7:0] RST_PERIOD_LIMIT = 8'hff;
	localparam logic [7:0] RST_DUTY_LOW = 8'h00;
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [2:0] RST_TIMER_CTRL = 3'h0;
	localparam logic [7:0] RST_DELAY_CFG = 8'h00;
	localparam logic [6:0] RST_SHUTDOWN = 7'h00;

	// Field positions
	localparam int CTRL_DIR_BIT = 7;
	localparam int CTRL_CFG_LSB = 6;
	localparam int CTRL_DUTY_LSB = 4;
	localparam int CTRL_MODE_LSB = 2;
	localparam int CTRL_POL_LSB = 0;
	localparam int TCON_ON_BIT = 2;
	localparam int TCON_PRESC_LSB = 0;
	localparam int DEL_RSEN_BIT = 7;
	localparam int DEL_COUNT_LSB = 0;
	localparam int SD_FLAG_BIT = 7;
	localparam int SD_SRC_LSB = 4;
	localparam int SD_AC_LSB = 2;
	localparam int SD_BD_LSB = 0;

	// Output arrangements
	localparam logic [1:0] CFG_SINGLE = 2'h0;
	localparam logic [1:0] CFG_FULL_FWD = 2'h1;
	localparam logic [1:0] CFG_HALF = 2'h2;
	localparam logic [1:0] CFG_FULL_REV = 2'h3;

	// Mode field value that enables PWM output drive
	localparam logic [1:0] MODE_PWM = 2'h3;

	// Timing: oscillator periods per instruction cycle
	localparam int OSC_PER_TCY = 4;
	localparam logic [1:0] Q_LAST = 2'(OSC_PER_TCY - 1);

	// AHB encodings
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [0:0] {
		EBP_BUS_IDLE,
		EBP_BUS_WRITE
	} ebp_bus_t;

	// Last hclk count of one prescaled timer increment (4, 16 or 64 hclk)
	function automatic logic [5:0] ebp_presc_last(input logic [1:0] sel);
		logic [5:0] r;
		r = 6'h03;
		if (sel == 2'h1)
		begin
			r = 6'h0f;
		end
		else if (sel[1])
		begin
			r = 6'h3f;
		end
		return r;
	endfunction

	// Two fine bits that extend the timer for the duty compare
	function automatic logic [1:0] ebp_fine_bits(input logic [5:0] cnt, input logic [1:0] sel);
		logic [1:0] r;
		r = cnt[1:0];
		if (sel == 2'h1)
		begin
			r = cnt[3:2];
		end
		else if (sel[1])
		begin
			r = cnt[5:4];
		end
		return r;
	endfunction

endpackage

/* File: ebp_dead_band.sv */
// Purpose: Delays the inactive-to-active edge of one PWM signal
// Assumes: tick pulses once per instruction cycle
// Notes: Falling edges pass with one register stage only
`timescale 1ns/1ps
`default_nettype none
module ebp_dead_band
#(
	parameter int DB_W = 7
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic sig,
	input wire logic en,
	input wire logic tick,
	input wire logic [DB_W-1:0] count,
	output logic delayed
);

	logic [DB_W-1:0] remain;

	// Count down while the input is active; go active at zero
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			delayed <= 1'b0;
			remain <= '0;
		end
		else if (!sig)
		begin
			delayed <= 1'b0;
			remain <= count;
		end
		else if (!en || remain == '0)
		begin
			delayed <= 1'b1;
		end
		else if (tick)
		begin
			remain <= remain - 1'b1;
		end
	end

endmodule
`default_nettype wire

/* File: ebp_top.sv */
// Purpose: Enhanced bridge PWM with dead band, direction change and auto shutdown
// Assumes: hclk is the oscillator; AHB-Lite slave, single word transfers
// Notes: Shutdown inputs pass a two-stage synchroniser before use
//
// Functional notes
// - Period is (limit+1)*4*prescale oscillator clocks
// - Period match clears timer, sets output, loads shadow
// - No postscaler takes part in period
// - Duty is 10 bits: low reg plus control[5:4]
// - Duty applied at period match; shadow read-only
// - Output cleared when shadow and latch match timer
// - Duty beyond period keeps output active all period
// - Prescale 1, 4 or 16 from timer control[1:0]
// - Config selects single, half, full forward, reverse
// - Half-bridge: PWM on A, complement on B
// - Half-bridge delays active edges by dead band count
// - Dead band above duty keeps output inactive
// - Full-bridge: one held output, one modulated output
// - Full-bridge uses no dead band
// - Direction bit takes effect next PWM cycle
// - Direction change: last cycle swaps held, blanks modulated
// - Shutdown sources chosen by select field bits 6:4
// - Shutdown forces each pair high, low or off
// - Hardware sets shutdown flag and holds shutdown state
// - Auto restart clears flag; otherwise software clears
// - Shutdown holds whole period; resumes at next period
// - Flag writes ignored while shutdown condition active
// - Source select encoding: comparators and trip pin
// - State field: 00 low, 01 high, 1x off
// - Polarity bits set per pair active level
// - Controls load at period start; delay earlier too
`timescale 1ns/1ps
`default_nettype none
module ebp_top
	import ebp_pkg::*;
#(
	parameter int TIMER_W = 8,
	parameter int DB_W = 7
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic cmp1_in,
	input wire logic cmp2_in,
	input wire logic external_trip_pin,
	output logic bridge_out_a,
	output logic bridge_out_a_oe_n,
	output logic bridge_out_b,
	output logic bridge_out_b_oe_n,
	output logic bridge_out_c,
	output logic bridge_out_c_oe_n,
	output logic bridge_out_d,
	output logic bridge_out_d_oe_n
);

	// Registers
	logic [TIMER_W-1:0] period_limit_reg;
	logic [TIMER_W-1:0] period_timer;
	logic [7:0] duty_low_reg;
	logic [7:0] duty_shadow_reg;
	logic [1:0] duty_latch;
	logic [7:0] capture_pwm_control;
	logic [2:0] timer_control;
	logic [7:0] pwm_delay_restart_config;
	logic [6:0] shutdown_config_reg;
	logic shutdown_active_flag;

	// Bus state
	ebp_bus_t bus_state;
	logic [7:0] wr_addr;
	logic addr_ok;
	logic [7:0] rd_byte;
	logic [7:0] wdata;
	logic wr_now;

	// Timer and PWM core
	logic [5:0] tick_cnt;
	logic [5:0] tick_last;
	logic [1:0] fine_q;
	logic [1:0] qcnt;
	logic timer_on;
	logic inc;
	logic period_start;
	logic duty_hit;
	logic [9:0] duty_new;
	logic pwm_set;
	logic pwm_raw;

	// Buffered configuration
	logic [1:0] act_cfg;
	logic [1:0] act_pol;
	logic act_en;
	logic [DB_W-1:0] act_db;
	logic db_en;
	logic pa;
	logic pb;
	logic dir_swap;
	logic [3:0] act;

	// Shutdown
	logic [2:0] sd_s1;
	logic [2:0] sd_s2;
	logic sd_cond;
	logic sd_evt;
	logic sd_hold;
	logic sd_force;
	logic [1:0] st_ac;
	logic [1:0] st_bd;

	// Address phase acceptance
	always_comb
	begin
		addr_ok = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
	end

	// Bus phase tracking; writes land in the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			bus_state <= EBP_BUS_IDLE;
			wr_addr <= 8'h00;
		end
		else if (hready)
		begin
			case (bus_state)
				EBP_BUS_IDLE:
				begin
					if (addr_ok && hwrite)
					begin
						bus_state <= EBP_BUS_WRITE;
						wr_addr <= haddr[7:0];
					end
				end
				EBP_BUS_WRITE:
				begin
					if (!(addr_ok && hwrite))
					begin
						bus_state <= EBP_BUS_IDLE;
					end
					else
					begin
						wr_addr <= haddr[7:0];
					end
				end
				default:
				begin
					bus_state <= EBP_BUS_IDLE;
				end
			endcase
		end
	end

	always_comb
	begin
		wr_now = (bus_state == EBP_BUS_WRITE);
		wdata = hwdata[7:0];
	end

	// Read mux; unmapped offsets read zero
	always_comb
	begin
		rd_byte = 8'h00;
		if (haddr[7:0] == ADDR_PERIOD_LIMIT)
		begin
			rd_byte = 8'(period_limit_reg);
		end
		else if (haddr[7:0] == ADDR_PERIOD_TIMER)
		begin
			rd_byte = 8'(period_timer);
		end
		else if (haddr[7:0] == ADDR_DUTY_LOW)
		begin
			rd_byte = duty_low_reg;
		end
		else if (haddr[7:0] == ADDR_DUTY_SHADOW)
		begin
			rd_byte = duty_shadow_reg;
		end
		else if (haddr[7:0] == ADDR_CONTROL)
		begin
			rd_byte = capture_pwm_control;
		end
		else if (haddr[7:0] == ADDR_TIMER_CTRL)
		begin
			rd_byte = {5'h00, timer_control};
		end
		else if (haddr[7:0] == ADDR_DELAY_CFG)
		begin
			rd_byte = pwm_delay_restart_config;
		end
		else if (haddr[7:0] == ADDR_SHUTDOWN)
		begin
			rd_byte = {shutdown_active_flag, shutdown_config_reg};
		end
	end

	// Read data registered for the data phase; always OKAY, no wait
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (addr_ok && !hwrite)
			begin
				hrdata <= {24'h000000, rd_byte};
			end
		end
	end

	// Software registers; duty shadow has no write path
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			period_limit_reg <= TIMER_W'(RST_PERIOD_LIMIT);
			duty_low_reg <= RST_DUTY_LOW;
			capture_pwm_control <= RST_CONTROL;
			timer_control <= RST_TIMER_CTRL;
			pwm_delay_restart_config <= RST_DELAY_CFG;
			shutdown_config_reg <= RST_SHUTDOWN;
		end
		else if (wr_now)
		begin
			if (wr_addr == ADDR_PERIOD_LIMIT)
			begin
				period_limit_reg <= TIMER_W'(wdata);
			end
			else if (wr_addr == ADDR_DUTY_LOW)
			begin
				duty_low_reg <= wdata;
			end
			else if (wr_addr == ADDR_CONTROL)
			begin
				capture_pwm_control <= wdata;
			end
			else if (wr_addr == ADDR_TIMER_CTRL)
			begin
				timer_control <= wdata[2:0];
			end
			else if (wr_addr == ADDR_DELAY_CFG)
			begin
				pwm_delay_restart_config <= wdata;
			end
			else if (wr_addr == ADDR_SHUTDOWN)
			begin
				shutdown_config_reg <= wdata[6:0];
			end
		end
	end

	// Prescaler: one timer increment per 4, 16 or 64 hclk
	always_comb
	begin
		timer_on = timer_control[TCON_ON_BIT];
		tick_last = ebp_presc_last(timer_control[TCON_PRESC_LSB +: 2]);
		fine_q = ebp_fine_bits(tick_cnt, timer_control[TCON_PRESC_LSB +: 2]);
		inc = timer_on && (tick_cnt == tick_last);
		period_start = inc && (period_timer == period_limit_reg);
		duty_new = {duty_low_reg, capture_pwm_control[CTRL_DUTY_LSB +: 2]};
		duty_hit = timer_on && ({duty_shadow_reg, duty_latch} == {8'(period_timer), fine_q});
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tick_cnt <= 6'h00;
		end
		else if (!timer_on || inc)
		begin
			tick_cnt <= 6'h00;
		end
		else
		begin
			tick_cnt <= tick_cnt + 6'h01;
		end
	end

	// Free quarter-cycle counter for instruction-cycle ticks
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			qcnt <= 2'h0;
		end
		else
		begin
			qcnt <= qcnt + 2'h1;
		end
	end

	// Period timer
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			period_timer <= '0;
		end
		else if (period_start)
		begin
			period_timer <= '0;
		end
		else if (inc)
		begin
			period_timer <= period_timer + 1'b1;
		end
	end

	// Duty double buffer and PWM set latch
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			duty_shadow_reg <= 8'h00;
			duty_latch <= 2'h0;
			pwm_set <= 1'b0;
		end
		else if (period_start)
		begin
			duty_shadow_reg <= duty_new[9:2];
			duty_latch <= duty_new[1:0];
			pwm_set <= (duty_new != 10'h000);
		end
		else if (duty_hit)
		begin
			pwm_set <= 1'b0;
		end
	end

	// Level drops in the cycle the count reaches the duty value, not one later
	always_comb
	begin
		pwm_raw = pwm_set && !duty_hit;
	end

	// Configuration buffered to the period boundary
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			act_cfg <= CFG_SINGLE;
			act_pol <= 2'h0;
			act_en <= 1'b0;
		end
		else if (period_start)
		begin
			act_cfg <= capture_pwm_control[CTRL_CFG_LSB +: 2];
			act_pol <= capture_pwm_control[CTRL_POL_LSB +: 2];
			act_en <= (capture_pwm_control[CTRL_MODE_LSB +: 2] == MODE_PWM);
		end
	end

	// Dead band count loads at the duty or period boundary
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			act_db <= '0;
		end
		else if (period_start || duty_hit)
		begin
			act_db <= pwm_delay_restart_config[DEL_COUNT_LSB +: DB_W];
		end
	end

	always_comb
	begin
		db_en = (act_cfg == CFG_HALF);
	end

	ebp_dead_band #(
		.DB_W(DB_W)
	) u_db_a (
		.hclk(hclk),
		.hresetn(hresetn),
		.sig(pwm_raw),
		.en(db_en),
		.tick(qcnt == Q_LAST),
		.count(act_db),
		.delayed(pa)
	);

	ebp_dead_band #(
		.DB_W(DB_W)
	) u_db_b (
		.hclk(hclk),
		.hresetn(hresetn),
		.sig(!pwm_raw),
		.en(db_en),
		.tick(qcnt == Q_LAST),
		.count(act_db),
		.delayed(pb)
	);

	// Logical output activity per arrangement
	always_comb
	begin
		dir_swap = act_cfg[0] && capture_pwm_control[CTRL_CFG_LSB]
			&& (capture_pwm_control[CTRL_DIR_BIT] != act_cfg[1])
			&& timer_on && (period_timer == period_limit_reg);
		act = 4'h0;
		case (act_cfg)
			CFG_SINGLE:
			begin
				act[0] = pa;
			end
			CFG_HALF:
			begin
				act[0] = pa;
				act[1] = pb;
			end
			CFG_FULL_FWD:
			begin
				act[0] = !dir_swap;
				act[2] = dir_swap;
				act[3] = pa && !dir_swap;
			end
			default:
			begin
				act[2] = !dir_swap;
				act[0] = dir_swap;
				act[1] = pa && !dir_swap;
			end
		endcase
	end

	// Shutdown input synchronisers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sd_s1 <= 3'h0;
			sd_s2 <= 3'h0;
		end
		else
		begin
			sd_s1 <= {external_trip_pin, cmp2_in, cmp1_in};
			sd_s2 <= sd_s1;
		end
	end

	always_comb
	begin
		sd_cond = |(shutdown_config_reg[SD_SRC_LSB +: 3] & sd_s2);
		sd_evt = sd_cond && (capture_pwm_control[CTRL_CFG_LSB +: 2] != CFG_SINGLE);
		sd_force = shutdown_active_flag || sd_hold;
		st_ac = shutdown_config_reg[SD_AC_LSB +: 2];
		st_bd = shutdown_config_reg[SD_BD_LSB +: 2];
	end

	// Shutdown flag: hardware set wins over any clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			shutdown_active_flag <= 1'b0;
		end
		else if (sd_evt)
		begin
			shutdown_active_flag <= 1'b1;
		end
		else if (wr_now && wr_addr == ADDR_SHUTDOWN)
		begin
			shutdown_active_flag <= wdata[SD_FLAG_BIT];
		end
		else if (pwm_delay_restart_config[DEL_RSEN_BIT])
		begin
			shutdown_active_flag <= 1'b0;
		end
	end

	// Hold shutdown until the first period start with the flag clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sd_hold <= 1'b0;
		end
		else if (shutdown_active_flag)
		begin
			sd_hold <= 1'b1;
		end
		else if (period_start)
		begin
			sd_hold <= 1'b0;
		end
	end

	// Pin stage: shutdown state, else polarity-adjusted activity
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			{bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d} <= 4'h0;
			{bridge_out_a_oe_n, bridge_out_b_oe_n} <= 2'h3;
			{bridge_out_c_oe_n, bridge_out_d_oe_n} <= 2'h3;
		end
		else if (sd_force || sd_evt)
		begin
			bridge_out_a <= !st_ac[1] && st_ac[0];
			bridge_out_c <= !st_ac[1] && st_ac[0];
			bridge_out_a_oe_n <= st_ac[1];
			bridge_out_c_oe_n <= st_ac[1];
			bridge_out_b <= !st_bd[1] && st_bd[0];
			bridge_out_d <= !st_bd[1] && st_bd[0];
			bridge_out_b_oe_n <= st_bd[1];
			bridge_out_d_oe_n <= st_bd[1];
		end
		else if (act_en)
		begin
			bridge_out_a <= act[0] ^ act_pol[1];
			bridge_out_c <= act[2] ^ act_pol[1];
			bridge_out_b <= act[1] ^ act_pol[0];
			bridge_out_d <= act[3] ^ act_pol[0];
			{bridge_out_a_oe_n, bridge_out_b_oe_n} <= 2'h0;
			{bridge_out_c_oe_n, bridge_out_d_oe_n} <= 2'h0;
		end
		else
		begin
			{bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d} <= 4'h0;
			{bridge_out_a_oe_n, bridge_out_b_oe_n} <= 2'h3;
			{bridge_out_c_oe_n, bridge_out_d_oe_n} <= 2'h3;
		end
	end

endmodule
`default_nettype wire

/* File: ebp_checker.sv */
// Purpose: Port assertions for the enhanced bridge PWM
// Assumes: Single word AHB transfers, hready tied to hreadyout
// Notes: Mirrors control, delay and shutdown writes seen on the bus
`timescale 1ns/1ps
`default_nettype none
module ebp_checker
	import ebp_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	input wire logic cmp1_in,
	input wire logic cmp2_in,
	input wire logic external_trip_pin,
	input wire logic bridge_out_a,
	input wire logic bridge_out_a_oe_n,
	input wire logic bridge_out_b,
	input wire logic bridge_out_b_oe_n,
	input wire logic bridge_out_c,
	input wire logic bridge_out_c_oe_n,
	input wire logic bridge_out_d,
	input wire logic bridge_out_d_oe_n
);
	logic wv_q;
	logic [7:0] wa_q, ctl_q, del_q, sd_q;
	logic acc, cause, ac_ok, bd_ok;
	assign acc = hsel && hready && htrans[1] && hsize == HSIZE_WORD;
	assign cause = (|({external_trip_pin, cmp2_in, cmp1_in} & sd_q[6:4]))
		&& ctl_q[7:6] != CFG_SINGLE && ctl_q[3:2] == MODE_PWM;
	assign ac_ok = sd_q[3] ? (bridge_out_a_oe_n && bridge_out_c_oe_n) : (!bridge_out_a_oe_n
		&& !bridge_out_c_oe_n && bridge_out_a == sd_q[2] && bridge_out_c == sd_q[2]);
	assign bd_ok = sd_q[1] ? (bridge_out_b_oe_n && bridge_out_d_oe_n) : (!bridge_out_b_oe_n
		&& !bridge_out_d_oe_n && bridge_out_b == sd_q[0] && bridge_out_d == sd_q[0]);
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wv_q <= 1'b0;
			wa_q <= 8'h00;
		end
		else
		begin
			wv_q <= acc && hwrite;
			wa_q <= haddr[7:0];
		end
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctl_q <= RST_CONTROL;
			del_q <= RST_DELAY_CFG;
			sd_q <= 8'h00;
		end
		else if (wv_q)
		begin
			if (wa_q == ADDR_CONTROL)
				ctl_q <= hwdata[7:0];
			if (wa_q == ADDR_DELAY_CFG)
				del_q <= hwdata[7:0];
			if (wa_q == ADDR_SHUTDOWN)
				sd_q <= {1'b0, hwdata[6:0]};
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence held_cause;
		cause [*4];
	endsequence
	sequence quiet_no_restart;
		(!cause && !del_q[7] && !(acc && hwrite)) [*8];
	endsequence
	a_hz_pin_low:
		assert property (!(bridge_out_a_oe_n && bridge_out_a) && !(bridge_out_b_oe_n
			&& bridge_out_b) && !(bridge_out_c_oe_n && bridge_out_c) && !(bridge_out_d_oe_n
			&& bridge_out_d)) else $error("Released pin not low");
	a_ac_shut_state:
		assert property (held_cause |-> ac_ok) else $error("Pair A/C not in shutdown state");
	a_bd_shut_state:
		assert property (held_cause |-> bd_ok) else $error("Pair B/D not in shutdown state");
	a_latch_no_restart:
		assert property (held_cause ##1 quiet_no_restart |-> ac_ok)
		else $error("Shutdown left without software clear");
	a_bridge_pair_excl:
		assert property (ctl_q[1:0] == 2'h0 && !(sd_q[2] && sd_q[0]) |-> !(bridge_out_a
			&& bridge_out_b) && !(bridge_out_c && bridge_out_d)) else $error("Both switches on");
	a_delay_readback:
		assert property (acc && !hwrite && haddr[7:0] == ADDR_DELAY_CFG |=> hrdata
			== {24'h0, $past(del_q)}) else $error("Delay register read wrong");
	a_resp_okay:
		assert property (!hresp) else $error("Error response seen");
	a_ready_high:
		assert property (hreadyout) else $error("Wait state inserted");
endmodule
bind ebp_top ebp_checker chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cmp1_in(cmp1_in),
	.cmp2_in(cmp2_in), .external_trip_pin(external_trip_pin), .bridge_out_a(bridge_out_a),
	.bridge_out_a_oe_n(bridge_out_a_oe_n), .bridge_out_b(bridge_out_b),
	.bridge_out_b_oe_n(bridge_out_b_oe_n), .bridge_out_c(bridge_out_c),
	.bridge_out_c_oe_n(bridge_out_c_oe_n), .bridge_out_d(bridge_out_d),
	.bridge_out_d_oe_n(bridge_out_d_oe_n));
`default_nettype wire

/* File: ebp_bridge_model.sv */
// Purpose: Switch driver inputs fed by the four bridge pins
// Assumes: Every driver input has a pull-down resistor
// Notes: A released pin reads low, so its switch stays off
`timescale 1ns/1ps
`default_nettype none
module ebp_bridge_model
(
	input wire logic pa,
	input wire logic pa_oe_n,
	input wire logic pb,
	input wire logic pb_oe_n,
	input wire logic pc,
	input wire logic pc_oe_n,
	input wire logic pd,
	input wire logic pd_oe_n,
	output logic [3:0] lvl
);
	// Pull-down wins while a pin is released
	assign lvl = {pd_oe_n ? 1'b0 : pd, pc_oe_n ? 1'b0 : pc,
		pb_oe_n ? 1'b0 : pb, pa_oe_n ? 1'b0 : pa};
endmodule
`default_nettype wire

/* File: testbench.sv */
// Purpose: Register and pin level tests of the enhanced bridge PWM
// Assumes: Period limit 3 and duty 4 unless a test sets otherwise
// Notes: Pin activity is counted in cycles over one period
`timescale 1ns/1ps
`default_nettype none
module testbench
	import ebp_pkg::*;
;
	logic hclk, hresetn, hsel, hwrite, cmp1_in, cmp2_in, external_trip_pin;
	logic [31:0] haddr, hwdata, hrdata, rdat;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout, hresp, pa, pa_oe_n, pb, pb_oe_n, pc, pc_oe_n, pd, pd_oe_n;
	logic [3:0] lvl;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cyc = 0;
	ebp_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cmp1_in(cmp1_in),
		.cmp2_in(cmp2_in), .external_trip_pin(external_trip_pin), .bridge_out_a(pa),
		.bridge_out_a_oe_n(pa_oe_n), .bridge_out_b(pb), .bridge_out_b_oe_n(pb_oe_n),
		.bridge_out_c(pc), .bridge_out_c_oe_n(pc_oe_n), .bridge_out_d(pd),
		.bridge_out_d_oe_n(pd_oe_n));
	ebp_bridge_model drv_u (.pa(pa), .pa_oe_n(pa_oe_n), .pb(pb), .pb_oe_n(pb_oe_n), .pc(pc),
		.pc_oe_n(pc_oe_n), .pd(pd), .pd_oe_n(pd_oe_n), .lvl(lvl));
	always #50 hclk = ~hclk;
	task automatic conclude();
		$display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			conclude();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t read got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_n(input int got, input int exp);
		samples_checked++;
		if (got != exp)
		begin
			n_mismatch++;
			$display("BAD %0t pin count got %0d exp %0d", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rdat = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(rdat, {24'h0, e});
	endtask
	task automatic pins(input int n, input int ea, input int eb, input int ec, input int ed);
		int h[4] = '{0, 0, 0, 0};
		repeat (n)
		begin
			@(posedge hclk);
			for (int i = 0; i < 4; i++)
				h[i] += (lvl[i] === 1'b1) ? 1 : ((lvl[i] === 1'b0) ? 0 : 1000);
		end
		chk_n(h[0], ea);
		chk_n(h[1], eb);
		chk_n(h[2], ec);
		chk_n(h[3], ed);
	endtask
	task automatic run(input logic [7:0] ctl, input logic [7:0] tc, input int n,
		input int ea, input int eb, input int ec, input int ed);
		wr(ADDR_CONTROL, ctl);
		wr(ADDR_TIMER_CTRL, tc);
		repeat (2 * n + 80) @(posedge hclk);
		pins(n, ea, eb, ec, ed);
	endtask
	initial
	begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'h0;
		hsize = HSIZE_WORD;
		{external_trip_pin, cmp2_in, cmp1_in} = 3'h0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		rd(ADDR_PERIOD_LIMIT, RST_PERIOD_LIMIT);
		rd(ADDR_CONTROL, RST_CONTROL);
		rd(ADDR_SHUTDOWN, 8'h00);
		wr(ADDR_DELAY_CFG, 8'h85);
		rd(ADDR_DELAY_CFG, 8'h85);
		wr(8'h20, 8'h5a);
		rd(8'h20, 8'h00);
		wr(ADDR_DUTY_SHADOW, 8'h55);
		rd(ADDR_DUTY_SHADOW, 8'h00);
		$display("Register test done");
		wr(ADDR_DELAY_CFG, 8'h00);
		wr(ADDR_PERIOD_LIMIT, 8'h03);
		wr(ADDR_DUTY_LOW, 8'h01);
		for (int i = 0; i < 3; i++)
			run(8'h0c, 8'(4 + i), 16 << (2 * i), 4 << (2 * i), 0, 0, 0);
		run(8'h1c, 8'h04, 16, 5, 0, 0, 0);
		wr(ADDR_DUTY_LOW, 8'h00);
		run(8'h0c, 8'h04, 16, 0, 0, 0, 0);
		wr(ADDR_DUTY_LOW, 8'h01);
		$display("Period and duty test done");
		run(8'h8c, 8'h04, 16, 4, 12, 0, 0);
		wr(ADDR_DELAY_CFG, 8'h05);
		run(8'h8c, 8'h04, 16, 0, 0, 0, 0);
		$display("Half bridge test done");
		run(8'h4c, 8'h04, 16, 16, 0, 0, 4);
		run(8'hcc, 8'h04, 16, 0, 4, 16, 0);
		wr(ADDR_DUTY_LOW, 8'h10);
		run(8'hcc, 8'h04, 16, 0, 16, 16, 0);
		wr(ADDR_DUTY_LOW, 8'h01);
		$display("Full bridge test done");
		wr(ADDR_DELAY_CFG, 8'h00);
		wr(ADDR_SHUTDOWN, 8'h46);
		external_trip_pin <= 1'b1;
		repeat (6) @(posedge hclk);
		pins(8, 8, 0, 8, 0);
		chk({30'h0, pb_oe_n, pd_oe_n}, 32'h3);
		rd(ADDR_SHUTDOWN, 8'hc6);
		wr(ADDR_SHUTDOWN, 8'h46);
		rd(ADDR_SHUTDOWN, 8'hc6);
		external_trip_pin <= 1'b0;
		repeat (12) @(posedge hclk);
		rd(ADDR_SHUTDOWN, 8'hc6);
		pins(16, 16, 0, 16, 0);
		wr(ADDR_SHUTDOWN, 8'h46);
		rd(ADDR_SHUTDOWN, 8'h46);
		repeat (40) @(posedge hclk);
		pins(16, 0, 4, 16, 0);
		wr(ADDR_DELAY_CFG, 8'h80);
		for (int s = 0; s < 8; s++)
			for (int k = 0; k < 3; k++)
			begin
				wr(ADDR_SHUTDOWN, {1'b0, 3'(s), 4'h6});
				{external_trip_pin, cmp2_in, cmp1_in} <= 3'(1 << k);
				repeat (6) @(posedge hclk);
				rd(ADDR_SHUTDOWN, {1'(s >> k), 3'(s), 4'h6});
				{external_trip_pin, cmp2_in, cmp1_in} <= 3'h0;
				repeat (6) @(posedge hclk);
				rd(ADDR_SHUTDOWN, {1'b0, 3'(s), 4'h6});
			end
		$display("Shutdown test done");
		repeat (40) @(posedge hclk);
		run(8'hcf, 8'h04, 16, 16, 12, 0, 16);
		$display("Polarity test done");
		conclude();
	end
endmodule
`default_nettype wire
